/* src/lpc_pkg.sv */
/*
  constants for the line printer controller: register map, field
  positions, control codes and sizes.
  assumes a 32-bit avalon-mm slave port with byte addresses.
*/
package lpc_pkg;

  // register byte offsets
  localparam logic [3:0] OFS_CTRL_STATUS = 4'h0;
  localparam logic [3:0] OFS_CHAR_BUFFER = 4'h4;
  localparam logic [3:0] OFS_FORM_STATUS = 4'h8;

  // printer_ctrl_status_reg fields
  localparam int CS_IE_BIT    = 6;
  localparam int CS_READY_BIT = 7;
  localparam int CS_ERROR_BIT = 15;

  // form status fields
  localparam int FS_LINE_LSB = 0;
  localparam int FS_LEN_LSB  = 8;
  localparam int FS_LOAD_BIT = 16;
  localparam int FS_VALID_BIT = 17;

  // control codes
  localparam logic [7:0] CODE_LF         = 8'h0a;
  localparam logic [7:0] CODE_FF         = 8'h0c;
  localparam logic [7:0] CODE_CR         = 8'h0d;
  localparam logic [7:0] CODE_TAB_FIRST  = 8'h80;
  localparam logic [7:0] CODE_TAB_LAST   = 8'h8b;
  localparam logic [7:0] CODE_START_LOAD = 8'hee;
  localparam logic [7:0] CODE_STOP_LOAD  = 8'hef;

  // sizes
  localparam int LINE_CHARS   = 132;
  localparam int FORM_MAX     = 143;
  localparam int TAB_CHANNELS = 12;
  localparam int VFM_HALF     = 6;
  localparam int DEFAULT_FORM = 66;

  // interrupt defaults (vector taken as octal 200)
  localparam logic [8:0] IRQ_VECTOR_DEF = 9'h080;
  localparam logic [2:0] IRQ_LEVEL_DEF  = 3'h4;

  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;

endpackage : lpc_pkg

/* src/lpc_line_printer_controller.sv */
/*
  line printer controller: avalon-mm register slave, character
  intake, 132-column line buffer, vertical format memory with
  12 tab channels, print/feed sequencing and interrupt request.
  assumes a printer mechanism that accepts one character per
  valid pulse, prints on prn_print and raises prn_busy while
  printing; all inputs synchronous to mclk.
*/
// Design decisions made here: the Avalon-MM interface to the registers and the address map.
// Behaviour
// - accept characters only while ready is set
// - host writes singly, 132-character line buffer
// - line feed, form feed, return print line
// - lf one line, ff to next page
// - carriage return prints without paper motion
// - forms to 143 lines, 12 channels
// - many stops per line, stop on many lines
// - code 356 octal starts format loading
// - code 357 octal ends format loading
// - two characters per line, 12-bit entry
// - keep only six low bits per character
// - first char stops 1-6, second 7-12
// - codes 200-213 octal select channels 1-12
// - held tab skips at next line feed
// - first line stop 1, last stop 12
// - 200 octal goes to next form top
// - 201-212 octal skip to marked line
// - 213 octal goes to form's last line
// - no interrupt unless enable bit set
// - interrupt on ready or error
// - vectored, level 4, vector 200, settable
`timescale 1ns/10ps
`default_nettype none

module lpc_line_printer_controller #(
  parameter int         LINE_CHARS   = lpc_pkg::LINE_CHARS,
  parameter int         FORM_MAX     = lpc_pkg::FORM_MAX,
  parameter int         DEFAULT_FORM = lpc_pkg::DEFAULT_FORM,
  parameter logic [8:0] IRQ_VECTOR   = lpc_pkg::IRQ_VECTOR_DEF,
  parameter logic [2:0] IRQ_LEVEL    = lpc_pkg::IRQ_LEVEL_DEF
) (
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic        ce,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output var  logic [31:0] avs_readdata,
  output var  logic        avs_waitrequest,
  input  wire logic        prn_busy,
  input  wire logic        prn_error,
  output var  logic [7:0]  prn_char,
  output var  logic        prn_char_valid,
  output var  logic        prn_print,
  output var  logic [7:0]  prn_feed,
  output var  logic        bus_interrupt_request,
  output var  logic [8:0]  irq_vector,
  output var  logic [2:0]  irq_level
);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DECODE,
    ST_SCAN,
    ST_SEND,
    ST_FIRE,
    ST_DRAIN
  } lpc_state_t;

  // controller state apart from the line buffer and format memory
  typedef struct packed {
    lpc_state_t  st;
    logic        wait_q;
    logic [31:0] rdata;
    logic        ie;
    logic        err;
    logic        irq;
    logic [7:0]  chr;
    logic [7:0]  col;
    logic        loading;
    logic        half_pend;
    logic [5:0]  half;
    logic [7:0]  vptr;
    logic [7:0]  vlen;
    logic        vloaded;
    logic [7:0]  line;
    logic [3:0]  tab;
    logic [7:0]  idx;
    logic [7:0]  cnt;
    logic [7:0]  feed;
    logic [7:0]  oidx;
    logic [7:0]  pchar;
    logic        pvalid;
    logic        pprint;
    logic [7:0]  pfeed;
    logic [8:0]  vec;
    logic [2:0]  lvl;
  } lpc_regs_t;

  localparam lpc_regs_t RST_REGS = '{
    st:      ST_IDLE,
    wait_q:  1'b1,
    vec:     IRQ_VECTOR,
    lvl:     IRQ_LEVEL,
    default: '0
  };

  localparam logic [7:0] LCHARS = 8'(LINE_CHARS);
  localparam logic [7:0] FMAX   = 8'(FORM_MAX);
  localparam logic [7:0] FDEF   = 8'(DEFAULT_FORM);

  lpc_regs_t s_q;
  lpc_regs_t s_d;

  logic [7:0]  line_buf [LINE_CHARS];
  logic [11:0] vfm_mem  [FORM_MAX];

  logic        lb_we;
  logic [7:0]  lb_addr;
  logic [7:0]  lb_din;
  logic        vm_we;
  logic [7:0]  vm_addr;
  logic [11:0] vm_din;
  logic [7:0]  flen;
  logic        acc;
  logic        wr_ok;

  // wrap a line number into the form
  function automatic logic [7:0] wrap_line(
    input logic [8:0] a,
    input logic [7:0] len
  );
    logic [8:0] r;
    r = a;
    if (a >= {1'b0, len}) begin
      r = a - {1'b0, len};
    end
    return r[7:0];
  endfunction : wrap_line

  // tab stop present on a form line
  function automatic logic stop_hit(
    input logic [11:0] entry,
    input logic        valid,
    input logic [7:0]  ln,
    input logic [7:0]  len,
    input logic [3:0]  ch
  );
    logic hit;
    hit = 1'b0;
    case (ch)
      4'h1: begin
        hit = (ln == 8'h00);
      end
      4'hc: begin
        hit = (ln == len - 8'h01);
      end
      default: begin
        hit = valid & entry[ch - 4'h1];
      end
    endcase
    return hit;
  endfunction : stop_hit

  // first character holds stops 1-6, second stops 7-12
  function automatic logic [11:0] vfm_entry(
    input logic [5:0] first,
    input logic [5:0] second
  );
    return {second, first};
  endfunction : vfm_entry

  // vertical tab command codes
  function automatic logic tab_code(
    input logic [7:0] c
  );
    return (c >= lpc_pkg::CODE_TAB_FIRST) && (c <= lpc_pkg::CODE_TAB_LAST);
  endfunction : tab_code

  // channel number 1-12 of a tab command
  function automatic logic [3:0] tab_channel(
    input logic [7:0] c
  );
    return 4'(c - lpc_pkg::CODE_TAB_FIRST) + 4'h1;
  endfunction : tab_channel

  always_comb begin
    s_d     = s_q;
    lb_we   = 1'b0;
    lb_addr = s_q.col;
    lb_din  = s_q.chr;
    vm_we   = 1'b0;
    vm_addr = s_q.vptr;
    vm_din  = vfm_entry(s_q.half, s_q.chr[5:0]);
    flen    = s_q.vloaded ? s_q.vlen : FDEF;
    acc     = (avs_read | avs_write) & s_q.wait_q;
    wr_ok   = avs_write & ~s_q.wait_q & avs_byteenable[0];

    s_d.pvalid = 1'b0;
    s_d.pprint = 1'b0;
    s_d.err    = prn_error;

    // bus slave: one wait cycle per access
    s_d.wait_q = ~acc;
    if (acc && avs_read) begin
      s_d.rdata = '0;
      case (avs_address)
        lpc_pkg::OFS_CTRL_STATUS: begin
          s_d.rdata[lpc_pkg::CS_IE_BIT]    = s_q.ie;
          s_d.rdata[lpc_pkg::CS_READY_BIT] = (s_q.st == ST_IDLE);
          s_d.rdata[lpc_pkg::CS_ERROR_BIT] = s_q.err;
        end
        lpc_pkg::OFS_FORM_STATUS: begin
          s_d.rdata[lpc_pkg::FS_LINE_LSB +: 8] = s_q.line;
          s_d.rdata[lpc_pkg::FS_LEN_LSB +: 8]  = flen;
          s_d.rdata[lpc_pkg::FS_LOAD_BIT]      = s_q.loading;
          s_d.rdata[lpc_pkg::FS_VALID_BIT]     = s_q.vloaded;
        end
        default: begin
          s_d.rdata = '0;
        end
      endcase
    end
    if (wr_ok && avs_address == lpc_pkg::OFS_CTRL_STATUS) begin
      s_d.ie = avs_writedata[lpc_pkg::CS_IE_BIT];
    end

    // character path and print sequencing
    case (s_q.st)
      ST_IDLE: begin
        // only idle takes a character
        if (wr_ok && avs_address == lpc_pkg::OFS_CHAR_BUFFER) begin
          s_d.chr = avs_writedata[7:0];
          s_d.st  = ST_DECODE;
        end
      end
      ST_DECODE: begin
        s_d.st = ST_IDLE;
        // loading swallows every character but stop
        if (s_q.loading) begin
          if (s_q.chr == lpc_pkg::CODE_STOP_LOAD) begin
            s_d.loading = 1'b0;
            s_d.vlen    = s_q.vptr;
            if (s_q.half_pend && s_q.vptr < FMAX) begin
              vm_we    = 1'b1;
              vm_din   = vfm_entry(s_q.half, 6'h00);
              s_d.vlen = s_q.vptr + 8'h01;
            end
            s_d.vloaded   = (s_d.vlen != 8'h00);
            s_d.half_pend = 1'b0;
          end else if (s_q.vptr < FMAX) begin
            if (!s_q.half_pend) begin
              s_d.half      = s_q.chr[5:0];
              s_d.half_pend = 1'b1;
            end else begin
              vm_we         = 1'b1;
              s_d.vptr      = s_q.vptr + 8'h01;
              s_d.half_pend = 1'b0;
            end
          end
        end else if (s_q.chr == lpc_pkg::CODE_START_LOAD) begin
          s_d.loading   = 1'b1;
          s_d.vptr      = 8'h00;
          s_d.half_pend = 1'b0;
          s_d.vloaded   = 1'b0;
          s_d.line      = 8'h00;
        end else if (tab_code(s_q.chr)) begin
          s_d.tab = tab_channel(s_q.chr);
        end else if (s_q.chr == lpc_pkg::CODE_LF) begin
          s_d.oidx = 8'h00;
          if (s_q.tab != 4'h0) begin
            s_d.idx = wrap_line({1'b0, s_q.line} + 9'h001, flen);
            s_d.cnt = 8'h01;
            s_d.st  = ST_SCAN;
          end else begin
            s_d.feed = 8'h01;
            s_d.st   = ST_SEND;
          end
        end else if (s_q.chr == lpc_pkg::CODE_FF) begin
          s_d.feed = flen - s_q.line;
          s_d.oidx = 8'h00;
          s_d.st   = ST_SEND;
        end else if (s_q.chr == lpc_pkg::CODE_CR) begin
          s_d.feed = 8'h00;
          s_d.oidx = 8'h00;
          s_d.st   = ST_SEND;
        end else if (s_q.col < LCHARS) begin
          lb_we   = 1'b1;
          s_d.col = s_q.col + 8'h01;
        end
      end
      ST_SCAN: begin
        // walk forward to the next line carrying the held stop
        if (stop_hit(vfm_mem[s_q.idx], s_q.vloaded, s_q.idx, flen, s_q.tab)) begin
          s_d.feed = s_q.cnt;
          s_d.st   = ST_SEND;
        end else if (s_q.cnt >= flen) begin
          s_d.feed = 8'h01;
          s_d.st   = ST_SEND;
        end else begin
          s_d.idx = wrap_line({1'b0, s_q.idx} + 9'h001, flen);
          s_d.cnt = s_q.cnt + 8'h01;
        end
      end
      ST_SEND: begin
        // stream the accumulated line to the mechanism
        if (s_q.oidx < s_q.col) begin
          s_d.pchar  = line_buf[s_q.oidx];
          s_d.pvalid = 1'b1;
          s_d.oidx   = s_q.oidx + 8'h01;
        end else begin
          s_d.st = ST_FIRE;
        end
      end
      ST_FIRE: begin
        s_d.pprint = 1'b1;
        s_d.pfeed  = s_q.feed;
        s_d.line   = wrap_line({1'b0, s_q.line} + {1'b0, s_q.feed}, flen);
        s_d.col    = 8'h00;
        s_d.tab    = 4'h0;
        s_d.cnt    = 8'h00;
        s_d.st     = ST_DRAIN;
      end
      ST_DRAIN: begin
        // give the mechanism one cycle to raise busy
        if (s_q.cnt == 8'h00) begin
          s_d.cnt = 8'h01;
        end else if (!prn_busy) begin
          s_d.st = ST_IDLE;
        end
      end
      default: begin
        s_d.st = ST_IDLE;
      end
    endcase

    // irq follows the next state; vector and level are reloaded from the parameters
    s_d.irq = s_d.ie & ((s_d.st == ST_IDLE) | s_d.err);
    s_d.vec = IRQ_VECTOR;
    s_d.lvl = IRQ_LEVEL;
  end

  // state register, frozen while ce is low
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s_q <= RST_REGS;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  // memories carry no reset; validity is tracked in the state
  always_ff @(posedge mclk) begin
    if (ce && lb_we) begin
      line_buf[lb_addr] <= lb_din;
    end
    if (ce && vm_we) begin
      vfm_mem[vm_addr] <= vm_din;
    end
  end

  // every output straight from the state register
  assign avs_readdata          = s_q.rdata;
  assign avs_waitrequest       = s_q.wait_q;
  assign prn_char              = s_q.pchar;
  assign prn_char_valid        = s_q.pvalid;
  assign prn_print             = s_q.pprint;
  assign prn_feed              = s_q.pfeed;
  assign bus_interrupt_request = s_q.irq;
  assign irq_vector            = s_q.vec;
  assign irq_level             = s_q.lvl;

endmodule : lpc_line_printer_controller

`default_nettype wire

/* tb/lpc_printer_model.sv */
/*
  printer mechanism model: captures streamed characters and feeds.
  assumes controller outputs on mclk; busy time set by the bench.
*/
`timescale 1ns/10ps
`default_nettype none
module lpc_printer_model (
  input  wire logic       mclk,
  input  wire logic       nrst,
  input  wire logic [7:0] prn_char,
  input  wire logic       prn_char_valid,
  input  wire logic       prn_print,
  input  wire logic [7:0] prn_feed,
  input  wire logic [7:0] slow,
  input  wire logic       err,
  output var  logic       prn_busy,
  output var  logic       prn_error
);
  logic [7:0] got [0:255];
  logic [7:0] feed;
  int         cnt;
  int         last;
  int         prints;
  int         bz;
  assign prn_busy  = bz != 0;
  assign prn_error = err;
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cnt    <= 0;
      prints <= 0;
      bz     <= 0;
    end else begin
      if (bz != 0) bz <= bz - 1;
      if (prn_char_valid) begin
        got[cnt] <= prn_char;
        cnt      <= cnt + 1;
      end
      if (prn_print) begin
        last   <= cnt;
        cnt    <= 0;
        feed   <= prn_feed;
        prints <= prints + 1;
        bz     <= slow + 1;
      end
    end
  end
endmodule : lpc_printer_model
`default_nettype wire

/* tb/lpc_monitor.sv */
/*
  port checker for the controller.
  assumes bind to lpc_line_printer_controller, ce high.
*/
`timescale 1ns/10ps
`default_nettype none
module lpc_monitor #(
  parameter int         LINE_CHARS = 132,
  parameter logic [8:0] IRQ_VECTOR = 9'h080,
  parameter logic [2:0] IRQ_LEVEL  = 3'h4
) (
  input wire logic        mclk,
  input wire logic        nrst,
  input wire logic        ce,
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic        avs_waitrequest,
  input wire logic        prn_error,
  input wire logic        prn_char_valid,
  input wire logic        prn_print,
  input wire logic [7:0]  prn_feed,
  input wire logic        bus_interrupt_request,
  input wire logic [8:0]  irq_vector,
  input wire logic [2:0]  irq_level
);
  logic       ie_q, ld_q, tab_q;
  logic [7:0] ctl_q;
  logic [8:0] n_q;
  wire        done = ce & avs_write & ~avs_waitrequest & avs_byteenable[0];
  wire        chw  = done && avs_address == lpc_pkg::OFS_CHAR_BUFFER;
  wire  [7:0] wd   = avs_writedata[7:0];
  wire        ctl  = wd == lpc_pkg::CODE_LF || wd == lpc_pkg::CODE_FF || wd == lpc_pkg::CODE_CR;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      {ie_q, ld_q, tab_q, ctl_q, n_q} <= '0;
    end else begin
      if (done && avs_address == lpc_pkg::OFS_CTRL_STATUS) ie_q <= avs_writedata[lpc_pkg::CS_IE_BIT];
      if (chw && wd == lpc_pkg::CODE_START_LOAD) ld_q <= 1'b1;
      if (chw && wd == lpc_pkg::CODE_STOP_LOAD) ld_q <= 1'b0;
      if (chw && !ld_q && wd >= lpc_pkg::CODE_TAB_FIRST && wd <= lpc_pkg::CODE_TAB_LAST) tab_q <= 1'b1;
      if (chw && !ld_q && ctl) ctl_q <= wd;
      if (prn_print) begin
        tab_q <= 1'b0;
        n_q   <= '0;
      end else if (prn_char_valid) n_q <= n_q + 9'h001;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  sequence s_ctl;
    chw && !ld_q && ctl;
  endsequence
  sequence s_printed;
    ##[1:400] prn_print;
  endsequence
  AST_PRINT_ON_CTL: assert property (s_ctl |-> s_printed)
    else $error("control code not printed");
  AST_CR_STILL: assert property (prn_print && ctl_q == lpc_pkg::CODE_CR |-> prn_feed == 8'h00)
    else $error("return moved paper");
  AST_LF_ONE: assert property (prn_print && ctl_q == lpc_pkg::CODE_LF && !tab_q |-> prn_feed == 8'h01)
    else $error("line feed not one line");
  AST_LINE_MAX: assert property (n_q <= LINE_CHARS)
    else $error("line too long");
  AST_IRQ_GATE: assert property (!ie_q && !$past(ie_q) |-> !bus_interrupt_request)
    else $error("irq without enable");
  AST_IRQ_ERR: assert property ((ie_q && prn_error) [*3] |-> bus_interrupt_request)
    else $error("no irq on error");
  AST_VEC: assert property (irq_vector == IRQ_VECTOR && irq_level == IRQ_LEVEL)
    else $error("bad vector or level");
  AST_WAIT_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("wait low too long");
  AST_WAIT_ANS: assert property (ce && (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("no bus answer");
endmodule : lpc_monitor
bind lpc_line_printer_controller lpc_monitor #(
  .LINE_CHARS(LINE_CHARS), .IRQ_VECTOR(IRQ_VECTOR), .IRQ_LEVEL(IRQ_LEVEL)
) mon_u (
  .mclk(mclk), .nrst(nrst), .ce(ce), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_waitrequest(avs_waitrequest), .prn_error(prn_error), .prn_char_valid(prn_char_valid),
  .prn_print(prn_print), .prn_feed(prn_feed), .bus_interrupt_request(bus_interrupt_request),
  .irq_vector(irq_vector), .irq_level(irq_level)
);
`default_nettype wire

/* tb/lpc_line_printer_controller_tb_top.sv */
/*
  self-checking bench: bus tasks, print lines, format load, irq.
  assumes lpc_printer_model on the printer side.
*/
`timescale 1ns/10ps
`default_nettype none
module lpc_line_printer_controller_tb_top;
  logic        mclk = 0, nrst = 0, rd = 0, wr = 0, err = 0;
  logic [3:0]  adr = 4'h0, be = 4'hf;
  logic [31:0] wdat = 32'h0000_0000, rdat, a;
  logic [7:0]  slow = 8'h06;
  logic [11:0] stops [0:142];
  logic [7:0]  q [$];
  wire         busy, perr, pv, pp, irq, wreq;
  wire  [7:0]  pc, pf;
  wire  [31:0] rdata;
  wire  [8:0]  vec;
  wire  [2:0]  lvl;
  int          fails = 0, checked = 0, cyc = 0, seed = 6, line = 0, len = 66;
  always #10 mclk = ~mclk;
  lpc_line_printer_controller dut_u (.mclk(mclk), .nrst(nrst), .ce(1'b1), .avs_address(adr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wdat), .avs_byteenable(be), .avs_readdata(rdata),
    .avs_waitrequest(wreq), .prn_busy(busy), .prn_error(perr), .prn_char(pc), .prn_char_valid(pv),
    .prn_print(pp), .prn_feed(pf), .bus_interrupt_request(irq), .irq_vector(vec), .irq_level(lvl));
  lpc_printer_model m_u (.mclk(mclk), .nrst(nrst), .prn_char(pc), .prn_char_valid(pv), .prn_print(pp),
    .prn_feed(pf), .slow(slow), .err(err), .prn_busy(busy), .prn_error(perr));
  task report_and_stop;
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : report_and_stop
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      fails++;
      report_and_stop;
    end
  end
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask : chk
  task bus(input logic w, input logic [3:0] ad, input logic [31:0] d);
    @(posedge mclk);
    adr  <= ad;
    wdat <= d;
    wr   <= w;
    rd   <= !w;
    @(posedge mclk iff !wreq);
    rdat = rdata;
    wr   <= 1'b0;
    rd   <= 1'b0;
  endtask : bus
  task put(input logic [7:0] c);
    rdat = '0;
    while (!rdat[lpc_pkg::CS_READY_BIT]) bus(0, lpc_pkg::OFS_CTRL_STATUS, 0);
    bus(1, lpc_pkg::OFS_CHAR_BUFFER, {24'h0000_00, c});
  endtask : put
  task txt(input int n);
    repeat (n) begin
      q.push_back(8'h20 + ($random(seed) & 8'h3f));
      put(q[$]);
    end
  endtask : txt
  task prt(input logic [7:0] c, input int f);
    int p;
    p    = m_u.prints;
    slow <= 8'h06 + ($random(seed) & 8'h0f);
    put(c);
    bus(0, lpc_pkg::OFS_CTRL_STATUS, 0);
    chk("ready", rdat[lpc_pkg::CS_READY_BIT], 0);
    bus(1, lpc_pkg::OFS_CHAR_BUFFER, 32'h0000_005a);
    while (m_u.prints == p) @(posedge mclk);
    chk("feed", m_u.feed, f);
    chk("count", m_u.last, q.size() > 132 ? 132 : q.size());
    for (int i = 0; i < m_u.last; i++) chk("char", m_u.got[i], q[i]);
    q.delete();
    line = (line + f) % len;
    bus(0, lpc_pkg::OFS_FORM_STATUS, 0);
    chk("line", rdat[7:0], line);
  endtask : prt
  function int nf(input int ch);
    int t;
    for (int d = 1; d <= len; d++) begin
      t = (line + d) % len;
      if (ch == 0 ? t == 0 : ch == 11 ? t == len - 1 : stops[t][ch]) return d;
    end
    return 1;
  endfunction : nf
  initial begin
    repeat (16) @(posedge mclk);
    nrst <= 1'b1;
    be   <= 4'he;
    bus(1, lpc_pkg::OFS_CTRL_STATUS, 32'h0000_0040);
    be   <= 4'hf;
    bus(0, lpc_pkg::OFS_CTRL_STATUS, 0);
    chk("csr", rdat, 32'h0000_0080);
    bus(0, 4'hc, 0);
    chk("unmapped", rdat, 0);
    chk("vector", vec, lpc_pkg::IRQ_VECTOR_DEF);
    chk("level", lvl, lpc_pkg::IRQ_LEVEL_DEF);
    chk("irq off", irq, 0);
    bus(1, lpc_pkg::OFS_CTRL_STATUS, 32'h0000_0040);
    repeat (2) @(posedge mclk);
    chk("irq ready", irq, 1);
    err <= 1'b1;
    repeat (4) @(posedge mclk);
    put(lpc_pkg::CODE_CR);
    repeat (3) @(posedge mclk);
    chk("irq error", irq, 1);
    bus(1, lpc_pkg::OFS_CTRL_STATUS, 0);
    repeat (3) @(posedge mclk);
    chk("irq gated", irq, 0);
    bus(0, lpc_pkg::OFS_CTRL_STATUS, 0);
    chk("error", rdat[lpc_pkg::CS_ERROR_BIT], 1);
    err <= 1'b0;
    txt(5);
    prt(lpc_pkg::CODE_CR, 0);
    txt(1 + ($random(seed) & 31));
    prt(lpc_pkg::CODE_LF, 1);
    txt(134);
    prt(lpc_pkg::CODE_LF, 1);
    txt(3);
    prt(lpc_pkg::CODE_FF, len - line);
    put(lpc_pkg::CODE_START_LOAD);
    len  = 8;
    line = 0;
    for (int i = 0; i < 8; i++) begin
      a = $random(seed);
      a[7]  = a[7] && a[7:0] != lpc_pkg::CODE_STOP_LOAD;
      a[15] = a[15] && a[15:8] != lpc_pkg::CODE_STOP_LOAD;
      put(a[7:0]);
      put(a[15:8]);
      stops[i] = {a[13:8], a[5:0]};
    end
    stops[0][0]  = 1'b1;
    stops[7][11] = 1'b1;
    put(lpc_pkg::CODE_STOP_LOAD);
    bus(0, lpc_pkg::OFS_FORM_STATUS, 0);
    chk("form", rdat[17:0], 18'h2_0800);
    for (int ch = 0; ch < 12; ch++) begin
      put(lpc_pkg::CODE_TAB_FIRST + ch[7:0]);
      prt(lpc_pkg::CODE_LF, nf(ch));
    end
    report_and_stop;
  end
endmodule : lpc_line_printer_controller_tb_top
`default_nettype wire
